// ---- inc/scr_link_if.sv ----
// Interface carrying stamped packets and side fields from modulator to receiver.
`timescale 1ns/100ps
interface scr_link_if;
    import scr_pkg::*;
    logic valid;
    logic ready;
    logic [SCR_WORD_W-1:0] data;
    logic [SCR_STAMP_W-1:0] stamp;
    logic [SCR_CNT_W-1:0] deleted_null_count;
    logic [1:0] stamp_len;
    logic init_valid;
    logic [SCR_FILL_W-1:0] initial_buffer_state;
    logic [SCR_FILL_W-1:0] buffer_size_limit;
    modport tx
    (
        output valid, data, stamp, deleted_null_count, stamp_len,
        output init_valid, initial_buffer_state, buffer_size_limit,
        input ready
    );
    modport rx
    (
        input valid, data, stamp, deleted_null_count, stamp_len,
        input init_valid, initial_buffer_state, buffer_size_limit,
        output ready
    );
endinterface

// ---- inc/scr_pkg.sv ----
// Shared constants and the rule summary for the stream clock regenerator.
// Summary of operation
// - Loop regulates buffer toward half full.
// - Insert counted null packets before each packet.
// - Fill error steers oscillator through smoothing filter.
// - Modulator stamps each packet with symbol counter.
// - Local symbol counter compared at FIFO read.
// - Stamp phase error drives output clock loop.
// - Receiver applies transmitted initial buffer state in stamp mode; in fill mode it primes at SCR_HALF instead.
// - Receiver limits buffering to signalled size.
// - Stamp field is two or three bytes.
// - FIFO sized and preloaded against over/underflow.
package scr_pkg;
    localparam int SCR_WORD_W = 8;
    localparam int SCR_STAMP_W = 24;
    localparam int SCR_CNT_W = 8;
    localparam int SCR_DEPTH = 64;
    localparam int SCR_PTR_W = 6;
    localparam int SCR_FILL_W = 7;
    localparam logic [SCR_FILL_W-1:0] SCR_HALF = 7'h20;
    localparam logic [SCR_WORD_W-1:0] SCR_NULL_WORD = 8'hff;
    localparam int SCR_ACC_W = 24;
    localparam logic [SCR_ACC_W-1:0] SCR_NOMINAL_STEP = 24'h200000;
    localparam int SCR_FILT_SHIFT = 4;
    localparam int SCR_GAIN_SHIFT = 2;
    localparam logic [1:0] SCR_STAMP2 = 2'h2;
    localparam logic [1:0] SCR_STAMP3 = 2'h3;
    localparam logic [SCR_STAMP_W-1:0] SCR_MASK2 = 24'h00ffff;
    localparam logic [SCR_STAMP_W-1:0] SCR_MASK3 = 24'hffffff;
endpackage

// ---- tb/scr_link_asserts.sv ----
// Concurrent checks on the link between modulator and receiver.
`timescale 1ns/100ps
module scr_link_asserts
    import scr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic valid,
    input wire logic ready,
    input wire logic [SCR_WORD_W-1:0] data,
    input wire logic [SCR_STAMP_W-1:0] stamp,
    input wire logic [SCR_CNT_W-1:0] deleted_null_count,
    input wire logic [1:0] stamp_len,
    input wire logic init_valid
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_stall;
        valid && !ready;
    endsequence
    sequence s_take_then_long;
        valid && ready ##1 valid && stamp_len == SCR_STAMP3;
    endsequence
    a_valid_hold: assert property (s_stall |=> valid)
        else $error("link word dropped while stalled");
    a_data_hold: assert property (s_stall |=> $stable(data))
        else $error("link data changed while stalled");
    a_count_hold: assert property (s_stall |=> $stable(deleted_null_count))
        else $error("null count changed while stalled");
    a_stamp_hold: assert property (s_stall |=> $stable(stamp) && $stable(stamp_len))
        else $error("stamp changed while stalled");
    a_short_stamp: assert property (valid && stamp_len == SCR_STAMP2 |-> (stamp & ~SCR_MASK2) == 0)
        else $error("two byte stamp has upper bits set");
    a_stamp_order: assert property (s_take_then_long |-> stamp - $past(stamp) < 24'h000100)
        else $error("stamps out of order on link");
    a_reset_quiet: assert property ($rose(rst_b) |-> !valid && !init_valid)
        else $error("link not idle after reset");
    a_ready_after_reset: assert property ($rose(rst_b) |-> ##[0:2] ready)
        else $error("empty receiver refuses words");
endmodule

// ---- tb/tb.sv ----
// Testbench joining modulator and receiver across the link.
`timescale 1ns/100ps
module tb import scr_pkg::*;;
    logic core_clk = 1'b0, rst_b = 1'b0, symbol_clock = 1'b0, in_valid = 1'b0;
    logic mode_stamp = 1'b0, out_ready = 1'b0, drain = 1'b0, cfg_init_valid = 1'b0, osc_q = 1'b0;
    logic [1:0] cfg_stamp_len = SCR_STAMP3;
    logic [SCR_WORD_W-1:0] in_data = 8'h00, out_data;
    logic [SCR_CNT_W-1:0] in_dnc = 8'h00;
    logic [SCR_FILL_W-1:0] cfg_init_state = 7'h00, cfg_limit = 7'h00, fill_level;
    logic in_ready, out_valid, out_is_null, output_stream_clock;
    logic [SCR_STAMP_W-1:0] phase_error;
    logic [8:0] exp_q[$];
    int num_errors = 0, samples_checked = 0, toggles = 0, sym_div = 0;
    scr_link_if scr_link_if_i();
    scr_modulator scr_modulator_i (.core_clk(core_clk), .rst_b(rst_b), .symbol_clock(symbol_clock),
        .in_valid(in_valid), .in_data(in_data), .in_deleted_null_count(in_dnc), .cfg_stamp_len(cfg_stamp_len),
        .cfg_init_valid(cfg_init_valid), .cfg_initial_buffer_state(cfg_init_state),
        .cfg_buffer_size_limit(cfg_limit), .in_ready(in_ready), .link(scr_link_if_i));
    scr_receiver scr_receiver_i (.core_clk(core_clk), .rst_b(rst_b), .symbol_clock(symbol_clock),
        .mode_stamp(mode_stamp), .link(scr_link_if_i), .out_ready(out_ready), .out_valid(out_valid),
        .out_data(out_data), .out_is_null(out_is_null), .output_stream_clock(output_stream_clock),
        .phase_error(phase_error), .fill_level(fill_level));
    scr_link_asserts scr_link_asserts_i (.core_clk(core_clk), .rst_b(rst_b), .valid(scr_link_if_i.valid),
        .ready(scr_link_if_i.ready), .data(scr_link_if_i.data), .stamp(scr_link_if_i.stamp),
        .deleted_null_count(scr_link_if_i.deleted_null_count), .stamp_len(scr_link_if_i.stamp_len),
        .init_valid(scr_link_if_i.init_valid));
    // ----------------------------------------
    // Clock, symbol clock and output collector.
    // ----------------------------------------
    initial forever #2.5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        sym_div <= sym_div + 1;
        symbol_clock <= sym_div[1];
        out_ready <= drain & ~out_ready;
        osc_q <= output_stream_clock;
        if (rst_b && output_stream_clock !== osc_q)
            toggles <= toggles + 1;
        if (rst_b && out_valid === 1'b1 && out_ready)
            check({out_is_null, out_data}, exp_q.size() != 0 ? exp_q.pop_front() : 9'h000);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        samples_checked++;
        if (seen !== expected)
        begin
            num_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, expected);
        end
    endtask
    task automatic send(input logic [7:0] d, input logic [7:0] n);
        logic rdy;
        int i;
        in_data <= d;
        in_dnc <= n;
        in_valid <= 1'b1;
        rdy = 1'b0;
        for (i = 0; i < 300 && !rdy; i++)
        begin
            @(negedge core_clk);
            rdy = (in_ready === 1'b1);
            @(posedge core_clk);
        end
        check(rdy, 1'b1);
        repeat (n) exp_q.push_back({1'b1, SCR_NULL_WORD});
        exp_q.push_back({1'b0, d});
    endtask
    task automatic drain_all;
        int i;
        in_valid <= 1'b0;
        drain <= 1'b1;
        for (i = 0; i < 3000 && exp_q.size() != 0; i++)
            @(posedge core_clk);
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Test sequence and watchdog.
    // ----------------------------------------
    initial
    begin
        #250000;
        num_errors++;
        tally_and_finish;
    end
    initial
    begin
        int i, k;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        cfg_limit <= 7'h08;
        @(posedge core_clk);
        for (i = 1; i <= 40; i++)
        begin
            send(8'(i), 8'(i % 3));
            if (i == 10 || i == 31)
            begin
                in_valid <= 1'b0;
                repeat (12) @(posedge core_clk);
                check(fill_level, i == 10 ? 8 : 31);
                check(i == 10 ? scr_link_if_i.ready : out_valid, 0);
                cfg_limit <= 7'h00;
            end
        end
        drain_all();
        check(exp_q.size(), 0);
        check(toggles != 0, 1);
        for (k = 0; k < 2; k++)
        begin
            rst_b <= 1'b0;
            drain <= 1'b0;
            mode_stamp <= 1'b1;
            cfg_stamp_len <= k == 0 ? SCR_STAMP2 : SCR_STAMP3;
            cfg_init_valid <= 1'b1;
            cfg_init_state <= 7'h04;
            exp_q.delete();
            repeat (8) @(posedge core_clk);
            rst_b <= 1'b1;
            repeat (2) @(posedge core_clk);
            cfg_init_valid <= 1'b0;
            for (i = 1; i <= 6; i++)
                send(8'(i + 8'h40), 8'(i % 2));
            in_valid <= 1'b0;
            repeat (4) @(posedge core_clk);
            check(out_valid, 1);
            check(fill_level, 6);
            drain_all();
            check(exp_q.size(), 0);
            check(phase_error[23:8], 16'h0000);
        end
        tally_and_finish;
    end
endmodule

// ---- verilog/scr_modulator.sv ----
// Modulator end: stamps each incoming word with the symbol counter and forwards it.
`timescale 1ns/100ps
module scr_modulator
    import scr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic symbol_clock,
    input wire logic in_valid,
    input wire logic [SCR_WORD_W-1:0] in_data,
    input wire logic [SCR_CNT_W-1:0] in_deleted_null_count,
    input wire logic [1:0] cfg_stamp_len,
    input wire logic cfg_init_valid,
    input wire logic [SCR_FILL_W-1:0] cfg_initial_buffer_state,
    input wire logic [SCR_FILL_W-1:0] cfg_buffer_size_limit,
    output logic in_ready,
    scr_link_if.tx link
);
    typedef struct packed {
        logic [2:0] sym_sync;
        logic [SCR_STAMP_W-1:0] sym_cnt;
        logic [1:0] vld;
        logic [1:0][SCR_WORD_W-1:0] dat;
        logic [1:0][SCR_STAMP_W-1:0] stp;
        logic [1:0][SCR_CNT_W-1:0] dnc;
        logic wr;
        logic rd;
        logic rdy;
        logic [1:0] slen;
        logic init_valid;
        logic [SCR_FILL_W-1:0] init_state;
        logic [SCR_FILL_W-1:0] size_lim;
    } scr_mod_state_t;

    scr_mod_state_t st;
    scr_mod_state_t next_st;
    logic [SCR_STAMP_W-1:0] len_mask;
    logic push;
    logic pop;

    // ----------------------------------------
    // Symbol counter and two-entry buffer
    // ----------------------------------------
    always_comb
    begin
        next_st = st;
        len_mask = (st.slen == SCR_STAMP2) ? SCR_MASK2 : SCR_MASK3;
        next_st.sym_sync = {st.sym_sync[1:0], symbol_clock};
        if (st.sym_sync[1] && !st.sym_sync[2])
        begin
            next_st.sym_cnt = (st.sym_cnt + 24'h000001) & len_mask;
        end
        push = in_valid && st.rdy;
        pop = st.vld[st.rd] && link.ready;
        if (push)
        begin
            next_st.dat[st.wr] = in_data;
            next_st.stp[st.wr] = st.sym_cnt;
            next_st.dnc[st.wr] = in_deleted_null_count;
            next_st.vld[st.wr] = 1'b1;
            next_st.wr = ~st.wr;
        end
        if (pop)
        begin
            next_st.vld[st.rd] = 1'b0;
            next_st.rd = ~st.rd;
        end
        next_st.rdy = !next_st.vld[next_st.wr];
        next_st.slen = (cfg_stamp_len == SCR_STAMP2) ? SCR_STAMP2 : SCR_STAMP3;
        next_st.init_valid = cfg_init_valid;
        next_st.init_state = cfg_initial_buffer_state;
        next_st.size_lim = cfg_buffer_size_limit;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            st <= '0;
            st.slen <= SCR_STAMP3;
        end
        else
        begin
            st <= next_st;
        end
    end

    always_comb
    begin
        in_ready = st.rdy;
        link.valid = st.vld[st.rd];
        link.data = st.dat[st.rd];
        link.stamp = st.stp[st.rd];
        link.deleted_null_count = st.dnc[st.rd];
        link.stamp_len = st.slen;
        link.init_valid = st.init_valid;
        link.initial_buffer_state = st.init_state;
        link.buffer_size_limit = st.size_lim;
    end
endmodule

// ---- verilog/scr_receiver.sv ----
// Receiver end: FIFO, null insertion and output stream clock regeneration.
`timescale 1ns/100ps
module scr_receiver
    import scr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic symbol_clock,
    input wire logic mode_stamp,
    scr_link_if.rx link,
    input wire logic out_ready,
    output logic out_valid,
    output logic [SCR_WORD_W-1:0] out_data,
    output logic out_is_null,
    output logic output_stream_clock,
    output logic [SCR_STAMP_W-1:0] phase_error,
    output logic [SCR_FILL_W-1:0] fill_level
);
    // ----------------------------------------
    // Receiver state
    // ----------------------------------------
    typedef struct packed {
        logic [2:0] sym_sync;
        logic [SCR_STAMP_W-1:0] local_cnt;
        logic [SCR_PTR_W-1:0] wr;
        logic [SCR_PTR_W-1:0] rd;
        logic [SCR_FILL_W-1:0] fill;
        logic [SCR_FILL_W-1:0] limit;
        logic [SCR_CNT_W-1:0] nulls_left;
        logic [SCR_FILL_W-1:0] start_level;
        logic primed;
        logic rdy;
        logic signed [SCR_ACC_W-1:0] filt;
        logic [SCR_ACC_W-1:0] phase_acc;
        logic [SCR_STAMP_W-1:0] perr;
        logic ovalid;
        logic [SCR_WORD_W-1:0] odata;
        logic onull;
        logic oclk;
    } scr_rx_state_t;

    scr_rx_state_t st;
    scr_rx_state_t next_st;
    logic [SCR_WORD_W-1:0] mem_dat [SCR_DEPTH];
    logic [SCR_STAMP_W-1:0] mem_stp [SCR_DEPTH];
    logic [SCR_CNT_W-1:0] mem_dnc [SCR_DEPTH];
    logic [SCR_STAMP_W-1:0] len_mask;
    logic signed [SCR_ACC_W-1:0] err;
    logic signed [SCR_ACC_W-1:0] step;
    logic push;
    logic pop;
    logic slot_free;
    logic [SCR_STAMP_W-1:0] diff;

    // ----------------------------------------
    // Packet memory
    // ----------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem_dat[st.wr] <= link.data;
            mem_stp[st.wr] <= link.stamp;
            mem_dnc[st.wr] <= link.deleted_null_count;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        next_st = st;
        len_mask = (link.stamp_len == SCR_STAMP2) ? SCR_MASK2 : SCR_MASK3;
        push = link.valid && st.rdy;
        slot_free = !st.ovalid || out_ready;
        pop = 1'b0;
        diff = '0;

        // ----------------------------------------
        // Local symbol counter
        // ----------------------------------------
        // The count wraps at the stamp width, as the one in the modulator does.
        next_st.sym_sync = {st.sym_sync[1:0], symbol_clock};
        if (st.sym_sync[1] && !st.sym_sync[2])
        begin
            next_st.local_cnt = (st.local_cnt + 24'h000001) & len_mask;
        end

        // ----------------------------------------
        // Buffer limit and priming
        // ----------------------------------------
        // A zero or oversized limit falls back to the full depth.
        next_st.limit = (link.buffer_size_limit == '0 || link.buffer_size_limit > SCR_FILL_W'(SCR_DEPTH))
            ? SCR_FILL_W'(SCR_DEPTH) : link.buffer_size_limit;
        if (link.init_valid)
        begin
            next_st.start_level = link.initial_buffer_state;
            next_st.primed = 1'b0;
        end
        else if (!st.primed && st.fill >= (mode_stamp ? st.start_level : SCR_HALF))
        begin
            next_st.primed = 1'b1;
        end

        // ----------------------------------------
        // Output stage and null insertion
        // ----------------------------------------
        // A null in the output stage marks the gap before the head packet as done.
        if (slot_free)
        begin
            next_st.ovalid = 1'b0;
            if (st.nulls_left != '0)
            begin
                next_st.ovalid = 1'b1;
                next_st.odata = SCR_NULL_WORD;
                next_st.onull = 1'b1;
                next_st.nulls_left = st.nulls_left - 8'h01;
            end
            else if (st.primed && st.fill != '0)
            begin
                if (mem_dnc[st.rd] != '0 && !st.onull)
                begin
                    next_st.ovalid = 1'b1;
                    next_st.odata = SCR_NULL_WORD;
                    next_st.onull = 1'b1;
                    next_st.nulls_left = mem_dnc[st.rd] - 8'h01;
                end
                else
                begin
                    pop = 1'b1;
                    next_st.ovalid = 1'b1;
                    next_st.odata = mem_dat[st.rd];
                    next_st.onull = 1'b0;
                    next_st.rd = st.rd + 6'h01;
                    diff = (st.local_cnt - mem_stp[st.rd]) & len_mask;
                    next_st.perr = diff;
                end
            end
        end

        // ----------------------------------------
        // Write pointer, fill and ready
        // ----------------------------------------
        if (push)
        begin
            next_st.wr = st.wr + 6'h01;
        end
        next_st.fill = st.fill + SCR_FILL_W'(push) - SCR_FILL_W'(pop);
        next_st.rdy = next_st.fill < next_st.limit;

        // ----------------------------------------
        // Loop error, smoothing filter and oscillator
        // ----------------------------------------
        // The stamp error is read as a signed number of the stamp width.
        if (mode_stamp)
        begin
            if (link.stamp_len == SCR_STAMP2)
            begin
                err = SCR_ACC_W'(signed'(st.perr[15:0]));
            end
            else
            begin
                err = signed'(st.perr);
            end
        end
        else
        begin
            err = SCR_ACC_W'(signed'({1'b0, st.fill})) - SCR_ACC_W'(signed'({1'b0, SCR_HALF}));
        end
        next_st.filt = st.filt + ((err - st.filt) >>> SCR_FILT_SHIFT);
        step = signed'(SCR_NOMINAL_STEP) + (st.filt <<< SCR_GAIN_SHIFT);
        next_st.phase_acc = st.phase_acc + step;
        next_st.oclk = st.phase_acc[SCR_ACC_W-1];
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Reset leaves the buffer empty and the limit at full depth.
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            st <= '0;
            st.limit <= SCR_FILL_W'(SCR_DEPTH);
        end
        else
        begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Ready comes from a register so that the modulator sees a settled value.
    always_comb
    begin
        link.ready = st.rdy;
        out_valid = st.ovalid;
        out_data = st.odata;
        out_is_null = st.onull;
        output_stream_clock = st.oclk;
        phase_error = st.perr;
        fill_level = st.fill;
    end
endmodule
